// ---- inc/spd_pkg.sv ----
// Package with constants and types for the scratch pad parameter DMA channel
package spd_pkg;
  // ----------------------------------------------------------------
  // Scratch pad locations
  // ----------------------------------------------------------------
  localparam logic [8:0] SP_ENABLE_ADDR = 9'h0F9;
  localparam logic [8:0] SP_MODE_ADDR = 9'h0FA;
  localparam logic [8:0] SP_LOW_ADDR = 9'h0FB;
  localparam logic [8:0] SP_SIZE_ADDR = 9'h0FC;
  localparam logic [8:0] SP_COUNT_ADDR = 9'h0FD;
  localparam logic [8:0] SP_STEP_ADDR = 9'h0FE;
  localparam logic [8:0] SP_PORT_BASE = 9'h100;
  localparam logic [8:0] SP_PROG_CHANNEL = 9'h004;
  localparam logic [1:0] PROG_LAST_SECT = 2'h2;
  // ----------------------------------------------------------------
  // Field positions of the mode and high base address word and of the enable word
  // ----------------------------------------------------------------
  localparam int MODE_PROG_BIT = 12;
  localparam int MODE_CHAN_HI = 11;
  localparam int MODE_CHAN_LO = 10;
  localparam int MODE_ADIR_BIT = 9;
  localparam int MODE_DDIR_BIT = 8;
  localparam int MODE_HIGH_HI = 5;
  localparam int ENABLE_IRQ_BIT = 0;
  // ----------------------------------------------------------------
  // Reset values and types
  // ----------------------------------------------------------------
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [21:0] ADDR_RESET = 22'h000000;
  localparam int BUF_DEPTH = 2;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_RD_EN = 4'h1,
    ST_RD_MODE = 4'h2,
    ST_RD_SIZE = 4'h3,
    ST_RD_LOW = 4'h4,
    ST_RD_COUNT = 4'h5,
    ST_RD_STEP = 4'h6,
    ST_MOVE = 4'h7,
    ST_DRAIN = 4'h8,
    ST_DONE = 4'h9
  } spd_state_e;
endpackage

// ---- verilog/spd_channel.sv ----
// Scratch pad parameter DMA channel engine
`timescale 1ns/10ps

// Behaviour
// - Enable LSB 1 interrupts host, 0 transfers
// - Block holds size plus one halfwords
// - Next block starts last address plus one plus step
// - Count plus one blocks, then completion interrupt
// - Count zero moves exactly one block
// - Program bit selects channel 4, else 0-3
// - Address bit 9 low increments, high decrements
// - Data bit 8 low reads scratch pad
// - Mode bits 5-0 give address 21:16
// - Low word gives address bits 15:0
// - Fetch low and step only when enabled
// - Zero size aborts, skip remaining fetches
// - Start pulse triggers fetch, transfer, interrupt
// - Parameters read from fixed scratch pad addresses
// - Data through port 0x100 plus channel
// - Program sections, channels run one at a time
module spd_channel (
  input wire logic I_MCLK,
  input wire logic I_ARST_N,
  input wire logic I_CE,
  input wire logic I_START,
  output logic [8:0] O_SP_ADDR,
  output logic O_SP_RD,
  output logic O_SP_WR,
  output logic [15:0] O_SP_WDATA,
  input wire logic [15:0] I_SP_RDATA,
  output logic [21:0] O_MEM_ADDR,
  output logic O_MEM_REQ,
  output logic O_MEM_WR,
  output logic [15:0] O_MEM_WDATA,
  input wire logic I_MEM_READY,
  input wire logic I_MEM_RVALID,
  input wire logic [15:0] I_MEM_RDATA,
  output logic O_MEM_RREADY,
  output logic O_HOST_IRQ,
  output logic O_SUB_IRQ,
  output logic O_BUSY,
  output logic O_CFG_ERR
);
  import spd_pkg::*;

  typedef struct packed {
    spd_state_e st;
    logic start_s1;
    logic start_s2;
    logic start_s3;
    logic rd_wait;
    logic [15:0] mode;
    logic [15:0] size;
    logic [15:0] count;
    logic [15:0] step;
    logic [21:0] addr;
    logic [15:0] blk_left;
    logic [15:0] blk_cnt;
    logic [15:0] issued;
    logic [BUF_DEPTH-1:0][15:0] buf_data;
    logic [1:0] sect;
    logic [BUF_DEPTH-1:0] buf_vld;
    logic buf_wp;
    logic buf_rp;
    logic [8:0] sp_addr;
    logic sp_rd;
    logic sp_wr;
    logic [15:0] sp_wdata;
    logic [21:0] mem_addr;
    logic mem_req;
    logic mem_wr;
    logic [15:0] mem_wdata;
    logic mem_rready;
    logic host_irq;
    logic sub_irq;
    logic busy;
    logic cfg_err;
  } spd_state_s;

  spd_state_s s_q;
  spd_state_s s_d;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [21:0] addr_step(input logic [21:0] a, input logic dec);
    addr_step = dec ? a - 22'h000001 : a + 22'h000001;
  endfunction

  // Program words rotate over three ports, one per instruction section
  function automatic logic [1:0] next_sect(input logic [1:0] s);
    next_sect = (s == PROG_LAST_SECT) ? 2'h0 : s + 2'h1;
  endfunction

  function automatic logic [8:0] port_addr(input logic [15:0] m, input logic [1:0] s);
    if (m[MODE_PROG_BIT]) begin
      port_addr = SP_PORT_BASE + SP_PROG_CHANNEL + {7'h00, s};
    end else begin
      port_addr = SP_PORT_BASE + {7'h00, m[MODE_CHAN_HI:MODE_CHAN_LO]};
    end
  endfunction

  function automatic spd_state_s fetch(input spd_state_s x, input logic [8:0] a);
    fetch = x;
    fetch.sp_addr = a;
    fetch.sp_rd = 1'b1;
    fetch.rd_wait = 1'b1;
  endfunction

  logic to_sp;
  logic buf_full;
  logic buf_empty;

  always_comb begin
    to_sp = s_q.mode[MODE_DDIR_BIT];
    buf_full = &s_q.buf_vld;
    buf_empty = ~|s_q.buf_vld;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.start_s1 = I_START;
    s_d.start_s2 = s_q.start_s1;
    s_d.start_s3 = s_q.start_s2;
    s_d.sp_rd = 1'b0;
    s_d.sp_wr = 1'b0;
    s_d.host_irq = 1'b0;
    s_d.sub_irq = 1'b0;
    s_d.rd_wait = 1'b0;
    s_d.mem_rready = 1'b0;
    // Scratch pad side accepts at a fixed rate, so buffer drains freely
    if (to_sp && !buf_empty && s_q.busy) begin
      s_d.sp_addr = port_addr(s_q.mode, s_q.sect);
      s_d.sect = next_sect(s_q.sect);
      s_d.sp_wr = 1'b1;
      s_d.sp_wdata = s_q.buf_data[s_q.buf_rp];
      s_d.buf_vld[s_q.buf_rp] = 1'b0;
      s_d.buf_rp = ~s_q.buf_rp;
    end
    case (s_q.st)
      ST_IDLE: begin
        s_d.busy = 1'b0;
        // Pulses during a transfer are ignored: channels never overlap
        if (s_q.start_s2 && !s_q.start_s3) begin
          s_d = fetch(s_d, SP_ENABLE_ADDR);
          s_d.st = ST_RD_EN;
          s_d.busy = 1'b1;
          s_d.cfg_err = 1'b0;
        end
      end
      ST_RD_EN: begin
        if (!s_q.rd_wait) begin
          if (I_SP_RDATA[ENABLE_IRQ_BIT]) begin
            s_d.host_irq = 1'b1;
            s_d.st = ST_IDLE;
            s_d.busy = 1'b0;
          end else begin
            s_d = fetch(s_d, SP_MODE_ADDR);
            s_d.st = ST_RD_MODE;
          end
        end
      end
      ST_RD_MODE: begin
        if (!s_q.rd_wait) begin
          s_d.mode = I_SP_RDATA;
          s_d = fetch(s_d, SP_SIZE_ADDR);
          s_d.st = ST_RD_SIZE;
        end
      end
      ST_RD_SIZE: begin
        if (!s_q.rd_wait) begin
          s_d.size = I_SP_RDATA;
          if (I_SP_RDATA == WORD_RESET) begin
            s_d.cfg_err = 1'b1;
            s_d.st = ST_IDLE;
            s_d.busy = 1'b0;
          end else begin
            s_d = fetch(s_d, SP_LOW_ADDR);
            s_d.st = ST_RD_LOW;
          end
        end
      end
      ST_RD_LOW: begin
        if (!s_q.rd_wait) begin
          s_d.addr = {s_q.mode[MODE_HIGH_HI:0], I_SP_RDATA};
          s_d = fetch(s_d, SP_COUNT_ADDR);
          s_d.st = ST_RD_COUNT;
        end
      end
      ST_RD_COUNT: begin
        if (!s_q.rd_wait) begin
          s_d.count = I_SP_RDATA;
          s_d = fetch(s_d, SP_STEP_ADDR);
          s_d.st = ST_RD_STEP;
        end
      end
      ST_RD_STEP: begin
        if (!s_q.rd_wait) begin
          s_d.step = I_SP_RDATA;
          s_d.blk_left = s_q.size;
          s_d.blk_cnt = s_q.count;
          s_d.issued = WORD_RESET;
          s_d.sect = 2'h0;
          s_d.st = ST_MOVE;
        end
      end
      ST_MOVE: begin
        if (s_q.mem_req && I_MEM_READY) begin
          s_d.mem_req = 1'b0;
          if (s_q.blk_left == WORD_RESET) begin
            // Block end: jump from last address plus one by the step
            s_d.addr = s_q.addr + 22'h000001 + {6'h00, s_q.step};
            s_d.blk_left = s_q.size;
            if (s_q.blk_cnt == WORD_RESET) begin
              s_d.st = ST_DRAIN;
            end else begin
              s_d.blk_cnt = s_q.blk_cnt - 16'h0001;
            end
          end else begin
            s_d.addr = addr_step(s_q.addr, s_q.mode[MODE_ADIR_BIT]);
            s_d.blk_left = s_q.blk_left - 16'h0001;
          end
        end else if (!s_q.mem_req) begin
          if (to_sp) begin
            // Reads held back while buffer full so no word is lost
            if (!buf_full) begin
              s_d.mem_req = 1'b1;
              s_d.mem_wr = 1'b0;
              s_d.mem_addr = s_q.addr;
            end
          end else if (!s_q.rd_wait && s_q.issued == WORD_RESET) begin
            s_d = fetch(s_d, port_addr(s_q.mode, s_q.sect));
            s_d.sect = next_sect(s_q.sect);
            s_d.issued = 16'h0001;
          end else if (!s_q.rd_wait) begin
            s_d.mem_req = 1'b1;
            s_d.mem_wr = 1'b1;
            s_d.mem_addr = s_q.addr;
            s_d.mem_wdata = I_SP_RDATA;
            s_d.issued = WORD_RESET;
          end
        end
      end
      ST_DRAIN: begin
        // Last read may still be in flight when the final request is taken
        if (!to_sp || (buf_empty && s_q.issued == WORD_RESET)) begin
          s_d.st = ST_DONE;
        end
      end
      ST_DONE: begin
        s_d.sub_irq = 1'b1;
        s_d.busy = 1'b0;
        s_d.st = ST_IDLE;
      end
      default: begin
        s_d.st = ST_IDLE;
      end
    endcase
    // Read data from memory into buffer
    if (to_sp && I_MEM_RVALID && s_q.mem_rready) begin
      s_d.buf_data[s_q.buf_wp] = I_MEM_RDATA;
      s_d.buf_vld[s_q.buf_wp] = 1'b1;
      s_d.buf_wp = ~s_q.buf_wp;
    end
    // Reads still owed by memory, so drain waits for every word
    if (to_sp && s_q.mem_req && I_MEM_READY) begin
      s_d.issued = s_d.issued + 16'h0001;
    end
    if (to_sp && I_MEM_RVALID && s_q.mem_rready) begin
      s_d.issued = s_d.issued - 16'h0001;
    end
    s_d.mem_rready = to_sp && s_q.busy && !(&s_d.buf_vld);
    if (s_q.start_s2 && !s_q.start_s3 && s_q.busy) begin
      s_d.st = s_d.st;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      s_q <= '0;
    end else if (I_CE) begin
      s_q <= s_d;
    end
  end

  always_comb begin
    O_SP_ADDR = s_q.sp_addr;
    O_SP_RD = s_q.sp_rd;
    O_SP_WR = s_q.sp_wr;
    O_SP_WDATA = s_q.sp_wdata;
    O_MEM_ADDR = s_q.mem_addr;
    O_MEM_REQ = s_q.mem_req;
    O_MEM_WR = s_q.mem_wr;
    O_MEM_WDATA = s_q.mem_wdata;
    O_MEM_RREADY = s_q.mem_rready;
    O_HOST_IRQ = s_q.host_irq;
    O_SUB_IRQ = s_q.sub_irq;
    O_BUSY = s_q.busy;
    O_CFG_ERR = s_q.cfg_err;
  end
endmodule

// ---- verification/spd_channel_monitor.sv ----
// Port checker of the scratch pad DMA channel
`timescale 1ns/10ps
module spd_channel_monitor (
  input wire logic I_MCLK,
  input wire logic I_ARST_N,
  input wire logic [8:0] O_SP_ADDR,
  input wire logic O_SP_RD,
  input wire logic O_SP_WR,
  input wire logic [21:0] O_MEM_ADDR,
  input wire logic O_MEM_REQ,
  input wire logic I_MEM_READY,
  input wire logic O_HOST_IRQ,
  input wire logic O_SUB_IRQ,
  input wire logic O_BUSY,
  input wire logic O_CFG_ERR
);
  default clocking @(posedge I_MCLK); endclocking
  default disable iff (!I_ARST_N);
  a_rd_fixed_place: assert property (O_SP_RD |-> O_SP_ADDR inside {[9'h0F9:9'h0FE],
    [9'h100:9'h106]}) else $error("read off fixed places");
  a_wr_data_port: assert property (O_SP_WR |-> O_SP_ADDR inside {[9'h100:9'h106]})
    else $error("write off data ports");
  a_req_held: assert property (O_MEM_REQ && !I_MEM_READY |=>
    O_MEM_REQ && $stable(O_MEM_ADDR)) else $error("request dropped");
  a_sub_pulse: assert property (O_SUB_IRQ |=> !O_SUB_IRQ) else $error("long irq");
  a_host_pulse: assert property (O_HOST_IRQ |-> !O_MEM_REQ ##1 !O_HOST_IRQ)
    else $error("host irq wrong");
  a_err_no_move: assert property (O_CFG_ERR |-> !O_MEM_REQ && !O_SP_WR)
    else $error("move after size zero");
  a_err_no_fetch: assert property (O_CFG_ERR |-> O_SP_ADDR == 9'h0FC && !O_SP_RD)
    else $error("fetch after size zero");
  a_one_at_time: assert property (O_MEM_REQ || O_SP_WR |-> O_BUSY)
    else $error("move while idle");
endmodule

bind spd_channel spd_channel_monitor spd_channel_monitor_i (.I_MCLK(I_MCLK),
  .I_ARST_N(I_ARST_N), .O_SP_ADDR(O_SP_ADDR), .O_SP_RD(O_SP_RD), .O_SP_WR(O_SP_WR),
  .O_MEM_ADDR(O_MEM_ADDR), .O_MEM_REQ(O_MEM_REQ), .I_MEM_READY(I_MEM_READY),
  .O_HOST_IRQ(O_HOST_IRQ), .O_SUB_IRQ(O_SUB_IRQ), .O_BUSY(O_BUSY), .O_CFG_ERR(O_CFG_ERR));

// ---- verification/spd_scratch_model.sv ----
// Scratch pad model: answers reads, logs reads and writes
`timescale 1ns/10ps
module spd_scratch_model (
  input wire logic clk,
  input wire logic [8:0] addr,
  input wire logic rd,
  input wire logic wr,
  input wire logic [15:0] wdata,
  output logic [15:0] rdata
);
  logic [15:0] mem [0:511];
  logic [8:0] fetch_q[$];
  logic [24:0] wlog_q[$];
  logic [15:0] port_n;
  logic [1:0] age;
  initial begin
    rdata = 16'h0000;
    age = 2'h3;
    port_n = 16'h0000;
  end
  // Data only holds three cycles, then flips so a late sample is caught
  always @(posedge clk) begin
    if (rd) fetch_q.push_back(addr);
    if (wr) wlog_q.push_back({addr, wdata});
    age <= rd ? 2'h0 : (age == 2'h3 ? age : age + 2'h1);
    if (rd) rdata <= addr < 9'h100 ? mem[addr] : 16'hC000 | port_n;
    else if (age == 2'h2) rdata <= ~rdata;
    if (rd && addr >= 9'h100) port_n <= port_n + 16'h0001;
  end
endmodule

// ---- verification/spd_channel_bench.sv ----
// Self-checking bench of the scratch pad DMA channel
`timescale 1ns/10ps
module spd_channel_bench;
  import spd_pkg::*;
  logic I_MCLK, I_ARST_N, I_START, I_MEM_READY, I_MEM_RVALID, stall;
  logic [15:0] I_SP_RDATA, I_MEM_RDATA, O_SP_WDATA, O_MEM_WDATA;
  logic [8:0] O_SP_ADDR;
  logic [21:0] O_MEM_ADDR;
  logic O_SP_RD, O_SP_WR, O_MEM_REQ, O_MEM_WR, O_MEM_RREADY;
  logic O_HOST_IRQ, O_SUB_IRQ, O_BUSY, O_CFG_ERR;
  int n_errors, checks, cyc, host_n, sub_n;
  logic [21:0] aq[$];
  logic [15:0] rq[$], dq[$];
  spd_channel spd_channel_i (.I_MCLK(I_MCLK), .I_ARST_N(I_ARST_N), .I_CE(1'b1),
    .I_START(I_START), .O_SP_ADDR(O_SP_ADDR), .O_SP_RD(O_SP_RD), .O_SP_WR(O_SP_WR),
    .O_SP_WDATA(O_SP_WDATA), .I_SP_RDATA(I_SP_RDATA), .O_MEM_ADDR(O_MEM_ADDR),
    .O_MEM_REQ(O_MEM_REQ), .O_MEM_WR(O_MEM_WR), .O_MEM_WDATA(O_MEM_WDATA),
    .I_MEM_READY(I_MEM_READY), .I_MEM_RVALID(I_MEM_RVALID), .I_MEM_RDATA(I_MEM_RDATA),
    .O_MEM_RREADY(O_MEM_RREADY), .O_HOST_IRQ(O_HOST_IRQ), .O_SUB_IRQ(O_SUB_IRQ),
    .O_BUSY(O_BUSY), .O_CFG_ERR(O_CFG_ERR));
  spd_scratch_model spd_scratch_model_i (.clk(I_MCLK), .addr(O_SP_ADDR), .rd(O_SP_RD),
    .wr(O_SP_WR), .wdata(O_SP_WDATA), .rdata(I_SP_RDATA));
  initial begin
    I_MCLK = 0;
    forever #5 I_MCLK = ~I_MCLK;
  end
  // Memory side: stalls its ready, returns address-derived data in order
  always @(posedge I_MCLK) begin
    cyc++;
    host_n += O_HOST_IRQ;
    sub_n += O_SUB_IRQ;
    if (O_MEM_REQ && I_MEM_READY) begin
      aq.push_back(O_MEM_ADDR);
      if (O_MEM_WR) dq.push_back(O_MEM_WDATA);
      else rq.push_back(O_MEM_ADDR[15:0] ^ 16'h5A5A);
    end
    if (I_MEM_RVALID && O_MEM_RREADY) void'(rq.pop_front());
    #1;
    I_MEM_RVALID = rq.size() > 0;
    I_MEM_RDATA = rq.size() > 0 ? rq[0] : ~I_MEM_RDATA;
    I_MEM_READY = !stall || cyc[1:0] == 2'b00;
  end
  initial begin
    wait (cyc == 30000);
    n_errors++;
    test_done();
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic run(input logic [15:0] channel_enable_word, mode, low, size, cnt, step);
    int t;
    spd_scratch_model_i.mem[SP_ENABLE_ADDR] = channel_enable_word;
    spd_scratch_model_i.mem[SP_MODE_ADDR] = mode;
    spd_scratch_model_i.mem[SP_LOW_ADDR] = low;
    spd_scratch_model_i.mem[SP_SIZE_ADDR] = size;
    spd_scratch_model_i.mem[SP_COUNT_ADDR] = cnt;
    spd_scratch_model_i.mem[SP_STEP_ADDR] = step;
    spd_scratch_model_i.fetch_q.delete();
    spd_scratch_model_i.wlog_q.delete();
    spd_scratch_model_i.port_n = 16'h0000;
    aq.delete();
    dq.delete();
    host_n = 0;
    sub_n = 0;
    I_START = 1;
    repeat (3) @(posedge I_MCLK);
    #1 I_START = 0;
    for (t = 0; t < 3000 && !(sub_n || host_n || O_CFG_ERR); t++) @(posedge I_MCLK);
    repeat (20) @(posedge I_MCLK);
    #1 chk("busy at end", 0, O_BUSY);
  endtask
  task automatic xfer(input logic [15:0] mode, low, size, cnt, step);
    logic [21:0] a;
    logic [8:0] port, ord [6];
    int k;
    ord = '{SP_ENABLE_ADDR, SP_MODE_ADDR, SP_SIZE_ADDR, SP_LOW_ADDR, SP_COUNT_ADDR,
      SP_STEP_ADDR};
    a = {mode[5:0], low};
    k = 0;
    for (int i = 0; i < 6; i++) chk("fetch", ord[i], spd_scratch_model_i.fetch_q[i]);
    for (int b = 0; b <= cnt; b++) begin
      for (int w = 0; w <= size; w++) begin
        port = mode[12] ? SP_PORT_BASE + SP_PROG_CHANNEL + 9'(k % 3)
          : SP_PORT_BASE + {7'h00, mode[11:10]};
        chk("mem address", a, aq[k]);
        if (mode[8]) chk("pad write", {port, a[15:0] ^ 16'h5A5A},
          spd_scratch_model_i.wlog_q[k]);
        else chk("mem data", 16'hC000 | k, dq[k]);
        if (!mode[8]) chk("port read", port, spd_scratch_model_i.fetch_q[6 + k]);
        k++;
        if (w < size) a = mode[9] ? a - 22'h1 : a + 22'h1;
      end
      a = a + 22'h1 + step;
    end
    chk("word count", k, aq.size());
    chk("done irq", 1, sub_n);
  endtask
  task automatic t_host();
    run(16'h0001, 16'h0005, 16'h1111, 16'h0003, 16'h0001, 16'h0009);
    chk("host irq", 1, host_n);
    chk("no traffic", 0, aq.size());
    foreach (spd_scratch_model_i.fetch_q[i])
      chk("skipped fetch", 0, spd_scratch_model_i.fetch_q[i] inside {9'h0FB, 9'h0FE});
  endtask
  task automatic t_zero();
    run(16'h0000, 16'h0100, 16'h1234, 16'h0000, 16'h0002, 16'h0001);
    chk("config error", 1, O_CFG_ERR);
    chk("fetch count", 3, spd_scratch_model_i.fetch_q.size());
    chk("no traffic", 0, aq.size());
  endtask
  task automatic t_to_mem();
    logic [15:0] m;
    for (int ch = 0; ch < 4; ch++) begin
      m = {4'hE, ch[1:0], ch[0], 1'b0, 8'hEA};
      run(16'h0000, m, 16'hFFFE, 16'h0002, 16'h0001, 16'h0003);
      xfer(m, 16'hFFFE, 16'h0002, 16'h0001, 16'h0003);
    end
  endtask
  task automatic t_to_pad();
    stall = 1;
    for (int n = 0; n < 3; n += 2) begin
      run(16'h0000, 16'h1315, 16'h0040, 16'h0005, n[15:0], 16'h0002);
      xfer(16'h1315, 16'h0040, 16'h0005, n[15:0], 16'h0002);
    end
    stall = 0;
  endtask
  task automatic test_done();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    I_ARST_N = 0;
    I_START = 0;
    stall = 0;
    I_MEM_READY = 1;
    I_MEM_RVALID = 0;
    I_MEM_RDATA = 16'h0000;
    repeat (12) @(posedge I_MCLK);
    #1 I_ARST_N = 1;
    repeat (3) @(posedge I_MCLK);
    #1;
    t_host();
    t_zero();
    t_to_mem();
    t_to_pad();
    test_done();
  end
endmodule
